// ===== src/lpm_ctrl.sv
// low-power mode controller and row access sequencer of a serial memory
`timescale 1ns/1ps
// Function
// - opcode BAh then chip select rise: deep sleep
// - deep sleep ignores clock, input; output high-z
// - exit pulse wakes deep sleep after delay
// - output stays high-z during deep wake
// - opcode B9h then chip select rise: lowest sleep
// - lowest sleep ignores clock, input; output high-z
// - first falling select wakes within delay
// - output stays high-z during lowest wake
// - each access fetches one whole 64-bit row
// - access is fetch then restore of row
module lpm_ctrl #(
    parameter int DEEP_ENTRY = lpm_pkg::DEEP_ENTRY_CYC,
    parameter int DEEP_PULSE = lpm_pkg::DEEP_PULSE_CYC,
    parameter int DEEP_EXIT = lpm_pkg::DEEP_EXIT_CYC,
    parameter int LOW_ENTRY = lpm_pkg::LOW_ENTRY_CYC,
    parameter int LOW_EXIT = lpm_pkg::LOW_EXIT_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // spi pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic so_core_i,
    input wire logic so_core_en_i,
    output logic so_o,
    output logic so_oe_o,
    // power state
    output logic awake_o,
    output logic deep_sleep_o,
    output logic lowest_power_sleep_o,
    // array access requests from command logic
    input wire logic acc_req_i,
    input wire logic acc_wr_i,
    input wire logic [lpm_pkg::ROW_ADDR_W-1:0] acc_row_i,
    input wire logic [2:0] acc_byte_i,
    input wire logic [7:0] acc_wdata_i,
    output logic acc_busy_o,
    output logic acc_done_o,
    output logic [7:0] acc_rdata_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] cs_sy;
        logic [1:0] sck_sy;
        logic [1:0] si_sy;
        logic cs_d;
        logic sck_d;
        logic [7:0] shift;
        logic [3:0] nbits;
        lpm_pkg::lpm_state_t st;
        logic [lpm_pkg::CNT_W-1:0] cnt;
        logic [lpm_pkg::CNT_W-1:0] pulse;
        lpm_pkg::lpm_acc_t acc;
        logic acc_wr;
        logic [lpm_pkg::ROW_ADDR_W-1:0] acc_row;
        logic [2:0] acc_byte;
        logic [7:0] acc_wdata;
        logic acc_done;
        logic [7:0] acc_rdata;
        logic so;
        logic so_oe;
    } lpm_s_t;

    lpm_s_t s_ff;
    lpm_s_t nxt_s;

    // ------------------------------------------------------------
    // row memory
    // ------------------------------------------------------------
    logic mem_rd;
    logic mem_wr;
    logic [lpm_pkg::ROW_BITS-1:0] mem_rdata;
    logic [lpm_pkg::ROW_BITS-1:0] mem_wdata;
    logic cs_n;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;

    lpm_row_mem #(
        .ADDR_W(lpm_pkg::ROW_ADDR_W),
        .DATA_W(lpm_pkg::ROW_BITS)
    ) u_mem (
        .mclk_i(mclk_i),
        .rd_en_i(mem_rd),
        .rd_addr_i(s_ff.acc_row),
        .rd_data_o(mem_rdata),
        .wr_en_i(mem_wr),
        .wr_addr_i(s_ff.acc_row),
        .wr_data_i(mem_wdata)
    );

    // synchronised pin views and edges
    assign cs_n = s_ff.cs_sy[1];
    assign cs_rise = cs_n & ~s_ff.cs_d;
    assign cs_fall = ~cs_n & s_ff.cs_d;
    assign sck_rise = s_ff.sck_sy[1] & ~s_ff.sck_d;

    // whole row fetched, one byte merged on a write, whole row restored
    assign mem_rd = (s_ff.acc == lpm_pkg::AC_IDLE) & acc_req_i & awake_o;
    assign mem_wr = (s_ff.acc == lpm_pkg::AC_RESTORE);

    // merge write byte into fetched row
    always_comb
    begin
        mem_wdata = mem_rdata;
        if (s_ff.acc_wr)
        begin
            mem_wdata[s_ff.acc_byte*8 +: 8] = s_ff.acc_wdata;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.cs_sy = {s_ff.cs_sy[0], cs_n_i};
        nxt_s.sck_sy = {s_ff.sck_sy[0], sck_i};
        nxt_s.si_sy = {s_ff.si_sy[0], si_i};
        nxt_s.cs_d = s_ff.cs_sy[1];
        nxt_s.sck_d = s_ff.sck_sy[1];
        nxt_s.acc_done = 1'b0;

        // opcode capture of the first byte of each frame opened in normal state
        if (cs_n)
        begin
            nxt_s.nbits = 4'h0;
        end
        else if (sck_rise && s_ff.nbits != 4'h8 && s_ff.st == lpm_pkg::ST_NORMAL)
        begin
            nxt_s.shift = {s_ff.shift[6:0], s_ff.si_sy[1]};
            nxt_s.nbits = s_ff.nbits + 4'h1;
        end

        // power state machine
        case (s_ff.st)
            lpm_pkg::ST_NORMAL:
            begin
                if (cs_rise && s_ff.nbits == 4'h8)
                begin
                    if (s_ff.shift == lpm_pkg::OP_DEEP_SLEEP)
                    begin
                        nxt_s.st = lpm_pkg::ST_DEEP_ENTRY;
                        nxt_s.cnt = '0;
                    end
                    else if (s_ff.shift == lpm_pkg::OP_LOWEST_SLEEP)
                    begin
                        nxt_s.st = lpm_pkg::ST_LOW_ENTRY;
                        nxt_s.cnt = '0;
                    end
                end
            end
            lpm_pkg::ST_DEEP_ENTRY:
            begin
                nxt_s.cnt = s_ff.cnt + 1'b1;
                if (s_ff.cnt == lpm_pkg::CNT_W'(DEEP_ENTRY - 1))
                begin
                    nxt_s.st = lpm_pkg::ST_DEEP;
                    nxt_s.pulse = '0;
                end
            end
            lpm_pkg::ST_DEEP:
            begin
                // only chip select is watched; low time measured
                if (cs_n)
                begin
                    nxt_s.pulse = '0;
                end
                else if (s_ff.pulse != lpm_pkg::CNT_W'(DEEP_PULSE - 1))
                begin
                    nxt_s.pulse = s_ff.pulse + 1'b1;
                end
                else
                begin
                    nxt_s.st = lpm_pkg::ST_DEEP_WAKE;
                    nxt_s.cnt = '0;
                end
            end
            lpm_pkg::ST_DEEP_WAKE:
            begin
                nxt_s.cnt = s_ff.cnt + 1'b1;
                if (s_ff.cnt == lpm_pkg::CNT_W'(DEEP_EXIT - 1))
                begin
                    nxt_s.st = lpm_pkg::ST_NORMAL;
                end
            end
            lpm_pkg::ST_LOW_ENTRY:
            begin
                nxt_s.cnt = s_ff.cnt + 1'b1;
                if (s_ff.cnt == lpm_pkg::CNT_W'(LOW_ENTRY - 1))
                begin
                    nxt_s.st = lpm_pkg::ST_LOW;
                end
            end
            lpm_pkg::ST_LOW:
            begin
                if (cs_fall)
                begin
                    nxt_s.st = lpm_pkg::ST_LOW_WAKE;
                    nxt_s.cnt = '0;
                end
            end
            lpm_pkg::ST_LOW_WAKE:
            begin
                // opcodes in this window are dropped
                nxt_s.cnt = s_ff.cnt + 1'b1;
                if (s_ff.cnt == lpm_pkg::CNT_W'(LOW_EXIT - 1))
                begin
                    nxt_s.st = lpm_pkg::ST_NORMAL;
                end
            end
            default:
            begin
                nxt_s.st = lpm_pkg::ST_NORMAL;
            end
        endcase

        // a frame still open on return starts no opcode mid-stream
        if (s_ff.st != lpm_pkg::ST_NORMAL && !cs_n)
        begin
            nxt_s.nbits = 4'h8;
            nxt_s.shift = 8'h00;
        end

        // array access sequencer
        case (s_ff.acc)
            lpm_pkg::AC_IDLE:
            begin
                if (mem_rd)
                begin
                    nxt_s.acc = lpm_pkg::AC_FETCH;
                    nxt_s.acc_wr = acc_wr_i;
                    nxt_s.acc_row = acc_row_i;
                    nxt_s.acc_byte = acc_byte_i;
                    nxt_s.acc_wdata = acc_wdata_i;
                end
            end
            lpm_pkg::AC_FETCH:
            begin
                nxt_s.acc = lpm_pkg::AC_RESTORE;
            end
            lpm_pkg::AC_RESTORE:
            begin
                nxt_s.acc = lpm_pkg::AC_IDLE;
                nxt_s.acc_done = 1'b1;
                nxt_s.acc_rdata = mem_rdata[s_ff.acc_byte*8 +: 8];
            end
            default:
            begin
                nxt_s.acc = lpm_pkg::AC_IDLE;
            end
        endcase

        // serial output: core drives only while awake
        if (nxt_s.st == lpm_pkg::ST_NORMAL)
        begin
            nxt_s.so = so_core_i;
            nxt_s.so_oe = so_core_en_i;
        end
        else
        begin
            nxt_s.so = 1'b0;
            nxt_s.so_oe = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s_ff <= '{cs_sy: 2'h3, sck_sy: 2'h0, si_sy: 2'h0, cs_d: 1'b1, sck_d: 1'b0,
                      shift: 8'h00, nbits: 4'h0, st: lpm_pkg::ST_NORMAL,
                      cnt: '0, pulse: '0, acc: lpm_pkg::AC_IDLE, acc_wr: 1'b0,
                      acc_row: '0, acc_byte: 3'h0, acc_wdata: 8'h00, acc_done: 1'b0,
                      acc_rdata: 8'h00, so: 1'b0, so_oe: 1'b0};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // outputs
    assign so_o = s_ff.so;
    assign so_oe_o = s_ff.so_oe;
    assign awake_o = (s_ff.st == lpm_pkg::ST_NORMAL);
    assign deep_sleep_o = (s_ff.st == lpm_pkg::ST_DEEP);
    assign lowest_power_sleep_o = (s_ff.st == lpm_pkg::ST_LOW);
    assign acc_busy_o = (s_ff.acc != lpm_pkg::AC_IDLE);
    assign acc_done_o = s_ff.acc_done;
    assign acc_rdata_o = s_ff.acc_rdata;
endmodule

// ===== src/lpm_pkg.sv
// constants and types shared by the low-power mode controller
package lpm_pkg;
    // sleep opcodes
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hBA;
    localparam logic [7:0] OP_LOWEST_SLEEP = 8'hB9;
    // timing, in ns, and derived cycle counts at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEEP_SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int DEEP_SLEEP_EXIT_PULSE_WIDTH_NS = 1000;
    localparam int DEEP_SLEEP_EXIT_DELAY_NS = 10000;
    localparam int LOWEST_SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int LOWEST_SLEEP_EXIT_DELAY_NS = 450000;
    // least times round up, longest times round down
    localparam int DEEP_ENTRY_CYC = (DEEP_SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEEP_PULSE_CYC = (DEEP_SLEEP_EXIT_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEEP_EXIT_CYC = (DEEP_SLEEP_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_ENTRY_CYC = (LOWEST_SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_EXIT_CYC = LOWEST_SLEEP_EXIT_DELAY_NS / CLK_PERIOD_NS;
    // array geometry and timer counter width
    localparam int ROW_BITS = 64;
    localparam int ROW_ADDR_W = 18;
    localparam int CNT_W = 20;
    // power states, one-hot
    typedef enum logic [6:0] {
        ST_NORMAL = 7'h01,
        ST_DEEP_ENTRY = 7'h02,
        ST_DEEP = 7'h04,
        ST_DEEP_WAKE = 7'h08,
        ST_LOW_ENTRY = 7'h10,
        ST_LOW = 7'h20,
        ST_LOW_WAKE = 7'h40
    } lpm_state_t;
    // array access phases, one-hot
    typedef enum logic [2:0] {
        AC_IDLE = 3'h1,
        AC_FETCH = 3'h2,
        AC_RESTORE = 3'h4
    } lpm_acc_t;
endpackage

// ===== src/lpm_row_mem.sv
// row-wide array storage with registered read data
`timescale 1ns/1ps
module lpm_row_mem #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 64
) (
    // clock
    input wire logic mclk_i,
    // read port
    input wire logic rd_en_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o,
    // write port
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [DATA_W-1:0] wr_data_i
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    // synchronous read and write
    always_ff @(posedge mclk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i)
        begin
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule

// ===== verif/lpm_ctrl_props.sv
// port checker for the low-power mode controller
`timescale 1ns/1ps
module lpm_ctrl_props #(
    parameter int DEEP_ENTRY = 4,
    parameter int LOW_ENTRY = 4
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // pins and power state
    input wire logic cs_n_i,
    input wire logic so_oe_o,
    input wire logic awake_o,
    input wire logic deep_sleep_o,
    input wire logic lowest_power_sleep_o,
    // array access
    input wire logic acc_req_i,
    input wire logic acc_busy_o,
    input wire logic acc_done_o
);
    // one clock domain throughout
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // output pin driven only in normal state
    a_oe_only_awake: assert property (so_oe_o |-> awake_o)
        else $error("so enabled outside normal state");
    a_one_state: assert property ($onehot0({awake_o, deep_sleep_o, lowest_power_sleep_o}))
        else $error("two power states at once");
    // entry waits its full delay
    a_deep_entry_wait: assert property ($rose(deep_sleep_o) |-> !$past(awake_o, DEEP_ENTRY))
        else $error("deep sleep entered too early");
    a_low_entry_wait: assert property ($rose(lowest_power_sleep_o) |-> !$past(awake_o, LOW_ENTRY))
        else $error("lowest sleep entered too early");
    // select held high keeps the device asleep
    a_deep_stays: assert property (cs_n_i[*4] ##0 deep_sleep_o |=> deep_sleep_o)
        else $error("deep sleep left without select");
    a_low_stays: assert property (cs_n_i[*4] ##0 lowest_power_sleep_o |=> lowest_power_sleep_o)
        else $error("lowest sleep left without select");
    // leaving sleep goes through a quiet wake interval
    a_deep_wake_quiet: assert property ($fell(deep_sleep_o) |-> !awake_o && !so_oe_o)
        else $error("deep sleep left straight to normal");
    a_low_wake_quiet: assert property ($fell(lowest_power_sleep_o) |-> !awake_o && !so_oe_o)
        else $error("lowest sleep left straight to normal");
    // fetch then restore, done on the third cycle
    a_access_steps: assert property (acc_req_i && !acc_busy_o && awake_o
        |=> acc_busy_o ##1 acc_busy_o ##1 (acc_done_o && !acc_busy_o))
        else $error("array access sequence wrong");
    a_done_single: assert property (acc_done_o |=> !acc_done_o)
        else $error("done longer than one cycle");
endmodule
bind lpm_ctrl lpm_ctrl_props #(.DEEP_ENTRY(DEEP_ENTRY), .LOW_ENTRY(LOW_ENTRY)) u_props (
    .mclk_i(mclk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o), .awake_o(awake_o),
    .deep_sleep_o(deep_sleep_o), .lowest_power_sleep_o(lowest_power_sleep_o),
    .acc_req_i(acc_req_i), .acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o));

// ===== verif/lpm_spi_host.sv
// spi host model driving select, serial clock and data
`timescale 1ns/1ps
module lpm_spi_host (
    // spi pins
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    // idle bus: select high, clock parked low
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // one frame, msb first, 80 ns clock only inside the frame
    task automatic frame(input logic [7:0] op, input int nbits);
        cs_n_o = 1'b0;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            si_o = op[i];
            #40 sck_o = 1'b1;
            #40 sck_o = 1'b0;
        end
        #40 cs_n_o = 1'b1;
        si_o = ~si_o; // released line shows no stale bit
    endtask
    // bare select pulse, clock and data left alone
    task automatic pulse(input int ns);
        cs_n_o = 1'b0;
        #(ns) cs_n_o = 1'b1;
    endtask
endmodule

// ===== verif/spi_memory_low_power_modes_test.sv
// testbench for the low-power mode controller
`timescale 1ns/1ps
module spi_memory_low_power_modes_test;
    localparam int DE = 6;
    localparam int DP = 5;
    localparam int DX = 9;
    localparam int LE = 7;
    localparam int LX = 20;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cs_n, sck, si, so_o, so_oe_o, awake_o, deep_sleep_o, lowest_power_sleep_o;
    logic acc_req = 1'b0, acc_wr = 1'b0, acc_busy_o, acc_done_o;
    logic so_core = 1'b1;
    logic so_core_en = 1'b1;
    logic [17:0] acc_row = 18'h0;
    logic [2:0] acc_byte = 3'h0;
    logic [7:0] acc_wdata = 8'h0, acc_rdata_o;
    int miscompares = 0;
    int cmp_count = 0;
    // design and host
    lpm_ctrl #(.DEEP_ENTRY(DE), .DEEP_PULSE(DP), .DEEP_EXIT(DX), .LOW_ENTRY(LE), .LOW_EXIT(LX)) uut (
        .mclk_i(mclk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .so_core_i(so_core), .so_core_en_i(so_core_en), .so_o(so_o), .so_oe_o(so_oe_o), .awake_o(awake_o),
        .deep_sleep_o(deep_sleep_o), .lowest_power_sleep_o(lowest_power_sleep_o),
        .acc_req_i(acc_req), .acc_wr_i(acc_wr), .acc_row_i(acc_row), .acc_byte_i(acc_byte),
        .acc_wdata_i(acc_wdata), .acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o), .acc_rdata_o(acc_rdata_o));
    lpm_spi_host host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task tick(input int k);
        repeat (k)
        begin
            @(posedge mclk_i);
            #1;
        end
    endtask
    // count cycles until a state flag reaches a level; sel 0 deep, 1 lowest, 2 awake
    task wait_for(input int sel, input logic lvl, output int n);
        n = 0;
        while ((sel == 0 ? deep_sleep_o : sel == 1 ? lowest_power_sleep_o : awake_o) !== lvl && n < 3000)
        begin
            if (sel == 2 && lvl === 1'b1 && so_oe_o !== 1'b0)
                chk("so_oe in wake", 0, so_oe_o);
            tick(1);
            n++;
        end
    endtask
    task enter_check(input int sel, input int exp);
        int n;
        wait_for(2, 1'b0, n);
        wait_for(sel, 1'b1, n);
        chk("entry cycles", exp, n);
        chk("so_oe asleep", 0, so_oe_o);
    endtask
    task wake_check(input int sel, input int exp);
        int n;
        wait_for(sel, 1'b0, n);
        wait_for(2, 1'b1, n);
        chk("wake cycles", exp, n);
    endtask
    // one array access; lat 10 means no answer expected
    task access(input logic wr, input logic [2:0] b, input logic [7:0] d, input int lat);
        int n;
        acc_req = 1'b1;
        acc_wr = wr;
        acc_row = 18'h5;
        acc_byte = b;
        acc_wdata = d;
        tick(1);
        acc_req = 1'b0;
        n = 0;
        while (acc_done_o !== 1'b1 && n < 10)
        begin
            tick(1);
            n++;
        end
        chk("access latency", lat, n);
    endtask
    task t_access;
        access(1'b1, 3'h0, 8'h3C, 2);
        access(1'b1, 3'h7, 8'h5A, 2);
        access(1'b0, 3'h0, 8'h00, 2);
        chk("row byte kept", 8'h3C, acc_rdata_o);
        access(1'b1, 3'h7, 8'hA5, 2);
        chk("fetched old byte", 8'h5A, acc_rdata_o);
    endtask
    task t_partial;
        host.frame(8'hBA, 7);
        tick(20);
        chk("awake after short frame", 1, awake_o);
        host.frame(8'hBB, 8);
        tick(20);
        chk("awake after other opcode", 1, awake_o);
    endtask
    task t_deep;
        host.frame(8'hBA, 8);
        enter_check(0, DE);
        access(1'b1, 3'h0, 8'hFF, 10);
        host.pulse(DP * 10 - 30);
        tick(20);
        chk("short pulse keeps sleep", 1, deep_sleep_o);
        fork
            host.pulse(DP * 10 + 30);
            wake_check(0, DX);
        join
        access(1'b0, 3'h0, 8'h00, 2);
        chk("row after deep sleep", 8'h3C, acc_rdata_o);
    endtask
    task t_lowest;
        host.frame(8'hB9, 8);
        enter_check(1, LE);
        fork
            host.frame(8'hBA, 8);
            wake_check(1, LX);
        join
        tick(DE + 20);
        chk("wake frame not decoded", 1, awake_o);
        chk("so_oe back in normal", 1, so_oe_o);
        // core output path live again after wake
        chk("so follows core high", 1, so_o);
        so_core = 1'b0;
        tick(1);
        chk("so follows core low", 0, so_o);
        so_core_en = 1'b0;
        tick(1);
        chk("so_oe follows core", 0, so_oe_o);
        so_core = 1'b1;
        so_core_en = 1'b1;
        tick(1);
        chk("so_oe restored", 1, so_oe_o);
    endtask
    // reset in mid-run while in deep sleep
    task t_reset;
        host.frame(8'hBA, 8);
        enter_check(0, DE);
        reset_i = 1'b1;
        tick(2);
        chk("deep cleared by reset", 0, deep_sleep_o);
        chk("so_oe off in reset", 0, so_oe_o);
        reset_i = 1'b0;
        tick(3);
        chk("awake after mid reset", 1, awake_o);
        chk("so_oe after mid reset", 1, so_oe_o);
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        #100000;
        miscompares++;
        $display("FAIL watchdog expected end seen hang");
        results;
    end
    // main sequence
    initial
    begin
        tick(10);
        reset_i = 1'b0;
        tick(3);
        chk("awake after reset", 1, awake_o);
        chk("sleep flags after reset", 0, {deep_sleep_o, lowest_power_sleep_o, acc_busy_o});
        t_access;
        t_partial;
        t_deep;
        t_lowest;
        t_reset;
        results;
    end
endmodule
